// ---- hdl/ltpc_top.sv ----
/*
 * ltpc_top: display timing, cascade pin direction, scan order, power
 * block enables and electronic volume of a dot-matrix lcd driver.
 * assumes: all inputs synchronous to clk; the display clock pin, frame
 * polarity pin and display-off pin are split into in/out/oe triples.
 */
`timescale 1ns/1ps
module ltpc_top (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // configuration straps
    input  wire logic                 internal_osc_select,
    input  wire logic                 master_mode,
    // command strobes from the command decoder
    input  wire logic                 power_wr,
    input  wire logic [2:0]           power_data,
    input  wire logic                 volume_wr,
    input  wire logic [5:0]           volume_data,
    input  wire logic                 scan_wr,
    input  wire logic                 scan_data,
    input  wire logic                 display_on_wr,
    input  wire logic                 display_on_data,
    // line data from display memory, independent of host accesses
    input  wire logic [131:0]         line_data,
    // cascade timing pins
    input  wire logic                 display_clock_pin_in,
    output logic                      display_clock_pin_out,
    output logic                      display_clock_pin_oe,
    input  wire logic                 frame_polarity_in,
    output logic                      frame_polarity_out,
    output logic                      frame_polarity_oe,
    input  wire logic                 display_off_sync_n_in,
    output logic                      display_off_sync_n_out,
    output logic                      display_off_sync_n_oe,
    // driver side
    output logic [131:0]              seg_out,
    output logic [5:0]                com_active,
    output logic                      com_enable,
    output logic                      drive_polarity,
    output logic                      line_fetch,
    output logic                      osc_running,
    output logic                      boost_en,
    output logic                      regulator_en,
    output logic                      follower_en,
    output logic [5:0]                volume_level
);
    // ----------------------------------------------------------------
    // settings registers
    // ----------------------------------------------------------------
    logic [2:0] power_block_enables_r, power_block_enables_nxt;
    logic [5:0] drive_level_volume_r,  drive_level_volume_nxt;
    logic       scan_reverse_r,        scan_reverse_nxt;
    logic       disp_on_r,             disp_on_nxt;

    // each setting holds until its command rewrites it
    always_comb begin
        power_block_enables_nxt = power_block_enables_r;
        drive_level_volume_nxt  = drive_level_volume_r;
        scan_reverse_nxt        = scan_reverse_r;
        disp_on_nxt             = disp_on_r;
        if (power_wr) begin
            power_block_enables_nxt = power_data;
        end
        if (volume_wr) begin
            drive_level_volume_nxt = volume_data;
        end
        if (scan_wr) begin
            scan_reverse_nxt = scan_data;
        end
        if (display_on_wr) begin
            disp_on_nxt = display_on_data;
        end
    end

    // reset puts volume at mid code and scan in normal order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_block_enables_r <= ltpc_pkg::PWR_RESET;
            drive_level_volume_r  <= ltpc_pkg::VOL_RESET;
            scan_reverse_r        <= ltpc_pkg::SCAN_RESET;
            disp_on_r             <= 1'b0;
        end else begin
            power_block_enables_r <= power_block_enables_nxt;
            drive_level_volume_r  <= drive_level_volume_nxt;
            scan_reverse_r        <= scan_reverse_nxt;
            disp_on_r             <= disp_on_nxt;
        end
    end

    // ----------------------------------------------------------------
    // power blocks and volume
    // ----------------------------------------------------------------
    // any pattern is accepted; only four are useful to the host
    assign boost_en     = power_block_enables_r[ltpc_pkg::PWR_BOOST_BIT];
    assign regulator_en = power_block_enables_r[ltpc_pkg::PWR_REG_BIT];
    assign follower_en  = power_block_enables_r[ltpc_pkg::PWR_FOLL_BIT];
    assign volume_level = ltpc_pkg::VOL_MAX - drive_level_volume_r;

    // ----------------------------------------------------------------
    // display clock source and internal oscillator
    // ----------------------------------------------------------------
    logic       osc_on;                       // oscillator allowed
    logic [6:0] osc_cnt_r, osc_cnt_nxt;       // divider count
    logic       osc_clk_r, osc_clk_nxt;       // internal display clock
    logic       ext_clk_r, ext_clk_nxt;       // last seen pin level
    logic       dclk_tick;                    // one display clock edge

    // slaves never run the oscillator; the booster needs it running,
    // which the host must arrange
    assign osc_on      = master_mode && internal_osc_select;
    assign osc_running = osc_on;

    always_comb begin
        osc_cnt_nxt = osc_cnt_r;
        osc_clk_nxt = osc_clk_r;
        if (!osc_on) begin
            osc_cnt_nxt = '0;
            osc_clk_nxt = 1'b0;
        end else if (osc_cnt_r == 7'(ltpc_pkg::OSC_DIV / 2 - 1)) begin
            osc_cnt_nxt = '0;
            osc_clk_nxt = !osc_clk_r;
        end else begin
            osc_cnt_nxt = osc_cnt_r + 7'h01;
        end
        ext_clk_nxt = display_clock_pin_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_r <= 7'h00;
            osc_clk_r <= 1'b0;
            ext_clk_r <= 1'b0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_clk_r <= osc_clk_nxt;
            ext_clk_r <= ext_clk_nxt;
        end
    end

    // rising edge of whichever clock is the source
    assign dclk_tick = osc_on
        ? (osc_clk_nxt && !osc_clk_r)
        : (display_clock_pin_in && !ext_clk_r);

    // ----------------------------------------------------------------
    // line and frame timing
    // ----------------------------------------------------------------
    logic [1:0] sub_r,   sub_nxt;     // display clocks within a line
    logic [5:0] line_r,  line_nxt;    // scan line 0..63
    logic       fr_r,    fr_nxt;      // internal frame polarity
    logic       fr_used;              // polarity actually driven

    always_comb begin
        sub_nxt  = sub_r;
        line_nxt = line_r;
        fr_nxt   = fr_r;
        if (dclk_tick) begin
            sub_nxt = sub_r + 2'h1;
            if (sub_r == 2'(ltpc_pkg::CLK_PER_LINE - 1)) begin
                line_nxt = line_r + 6'h01;
                if (line_r == 6'(ltpc_pkg::NUM_COM - 1)) begin
                    fr_nxt = !fr_r;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_r  <= 2'h0;
            line_r <= 6'h00;
            fr_r   <= 1'b0;
        end else begin
            sub_r  <= sub_nxt;
            line_r <= line_nxt;
            fr_r   <= fr_nxt;
        end
    end

    // a slave follows the master's polarity
    assign fr_used        = master_mode ? fr_r : frame_polarity_in;
    assign drive_polarity = fr_used;
    assign line_fetch     = dclk_tick && (sub_r == 2'h0);

    // ----------------------------------------------------------------
    // cascade pin directions
    // ----------------------------------------------------------------
    logic disp_on_used;                       // on state after cascade
    assign display_clock_pin_out  = osc_clk_r;
    assign display_clock_pin_oe   = osc_on;
    assign frame_polarity_out     = fr_r;
    assign frame_polarity_oe      = master_mode;
    assign display_off_sync_n_out = disp_on_r;
    assign display_off_sync_n_oe  = master_mode;
    assign disp_on_used = master_mode ? disp_on_r
                                      : display_off_sync_n_in;

    // ----------------------------------------------------------------
    // segment latch and common scan
    // ----------------------------------------------------------------
    logic [131:0] seg_latch_r, seg_latch_nxt; // display data latch

    // only loaded at a line fetch, so host memory traffic never shows
    always_comb begin
        seg_latch_nxt = seg_latch_r;
        if (line_fetch) begin
            seg_latch_nxt = line_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_latch_r <= '0;
        end else begin
            seg_latch_r <= seg_latch_nxt;
        end
    end

    // display off grounds every driver
    assign seg_out    = disp_on_used ? seg_latch_r : '0;
    assign com_enable = disp_on_used;
    assign com_active = scan_reverse_r ? (6'h3f - line_r) : line_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_vol_write;
        volume_wr && !display_on_wr;
    endsequence

    osc_stopped_a: assert property (@(posedge clk) disable iff (!rst_n)
        !osc_on |=> osc_clk_r == 1'b0)
        else $error("oscillator ran while not selected");
    seg_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !line_fetch |=> $stable(seg_latch_r))
        else $error("segment latch moved outside fetch");
    frame_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (dclk_tick && sub_r == 2'h3 && line_r == 6'h3f)
        |=> fr_r != $past(fr_r))
        else $error("frame polarity did not flip");
    master_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        master_mode |-> frame_polarity_oe && display_off_sync_n_oe
        && display_clock_pin_oe == internal_osc_select)
        else $error("master pin direction wrong");
    slave_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        !master_mode |-> !frame_polarity_oe && !display_clock_pin_oe
        && !display_off_sync_n_oe)
        else $error("slave drives a timing pin");
    scan_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        scan_reverse_r |-> com_active + line_r == 6'h3f)
        else $error("reverse scan order wrong");
    power_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        power_wr |=> {boost_en, regulator_en, follower_en}
        == $past(power_data))
        else $error("power enables not taken");
    volume_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_vol_write |=> volume_level == 6'h3f - $past(volume_data))
        else $error("volume level mismatch");
    off_ground_a: assert property (@(posedge clk) disable iff (!rst_n)
        !disp_on_used |-> seg_out == '0 && !com_enable)
        else $error("drivers active while display off");
endmodule

// ---- include/ltpc_pkg.sv ----
/*
 * ltpc_pkg: constants shared by the lcd timing and power control block.
 * assumes a single 20 MHz system clock; no bus, commands arrive as strobes.
 */
package ltpc_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned NUM_COM     = 64;   // common outputs 0..63
    localparam int unsigned NUM_SEG     = 132;  // segment outputs
    localparam int unsigned COM_W       = 6;    // common index width
    localparam int unsigned PWR_W       = 3;    // power enable width
    localparam int unsigned VOL_W       = 6;    // volume code width
    // ----------------------------------------------------------------
    // power enable bit positions
    // ----------------------------------------------------------------
    localparam int unsigned PWR_BOOST_BIT = 2;  // booster
    localparam int unsigned PWR_REG_BIT   = 1;  // voltage regulator
    localparam int unsigned PWR_FOLL_BIT  = 0;  // voltage follower
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] PWR_RESET = 3'h0;   // all blocks off
    localparam logic [5:0] VOL_RESET = 6'h20;  // binary 100000
    localparam logic [5:0] VOL_MAX   = 6'h3f;  // level = 63 - code
    localparam logic       SCAN_RESET = 1'b0;  // normal order
    // ----------------------------------------------------------------
    // timing: internal oscillator model and line timing
    // ----------------------------------------------------------------
    localparam int unsigned OSC_PERIOD_NS = 5000; // display clock period
    localparam int unsigned CLK_PERIOD_NS = 50;   // 20 MHz system clock
    localparam int unsigned OSC_DIV =
        (OSC_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (OSC_PERIOD_NS / CLK_PERIOD_NS);
    localparam int unsigned OSC_CNT_W = 7;        // holds OSC_DIV - 1
    localparam int unsigned CLK_PER_LINE = 4;     // display clocks a line
endpackage

// ---- testbench/ltpc_far_side.sv ----
/*
 * ltpc_far_side: cascade master seen from the timing pins.
 * assumes the bench sets run, pol and on; clk is the system clock.
 */
`timescale 1ns/1ps
module ltpc_far_side (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic pol,
    input  wire logic on,
    input  wire logic ck_o,
    input  wire logic ck_oe,
    input  wire logic fr_o,
    input  wire logic fr_oe,
    input  wire logic off_o,
    input  wire logic off_oe,
    output logic      ck_w,
    output logic      fr_w,
    output logic      off_w
);
    logic [5:0] div_r;  // half period count of the cascade clock
    logic       ck_r;   // cascade display clock
    // the clock stands still while run is low, as between frames
    always_ff @(posedge clk) begin
        if (!run) begin
            div_r <= 6'h00;
            ck_r  <= 1'b0;
        end else if (div_r == 6'h27) begin
            div_r <= 6'h00;
            ck_r  <= ~ck_r;
        end else begin
            div_r <= div_r + 6'h01;
        end
    end
    // a pin is the block's own only while its enable is up
    assign ck_w  = ck_oe ? ck_o : ck_r;
    assign fr_w  = fr_oe ? fr_o : pol;
    assign off_w = off_oe ? off_o : on;
endmodule

// ---- testbench/tb_lcd_timing_and_power_control.sv ----
/*
 * tb_lcd_timing_and_power_control: queued self-check of ltpc_top.
 * assumes ltpc_far_side stands on the three cascade pins.
 */
`timescale 1ns/1ps
module tb_lcd_timing_and_power_control;
    logic         clk, rst_n, osel, mst, pwr_wr, vol_wr, scn_wr, on_wr;
    logic         scn_d, on_d, run, pol, on, ck_w, fr_w, off_w, fo;
    logic         ck_o, ck_oe, fr_o, fr_oe, off_o, off_oe, com_en;
    logic         drv_pol, fetch, osc, bst, rg, fl;
    logic [2:0]   pwr_d;
    logic [5:0]   vol_d, com, vol_lv, v;
    logic [131:0] line_d, seg, old;
    int           n_fail, check_count, seed, cyc, gap, i;
    logic [131:0] exp_q[$];  // expected values, oldest first
    int           id_q[$];   // which output each note is about
    event         chk_ev;
    string nm[10] = '{"power", "volume", "pin_oe", "osc", "com_en",
                      "seg", "polarity", "com", "off_pin", "frame_gap"};
    ltpc_top DUT (.clk(clk), .rst_n(rst_n), .internal_osc_select(osel),
        .master_mode(mst), .power_wr(pwr_wr), .power_data(pwr_d),
        .volume_wr(vol_wr), .volume_data(vol_d), .scan_wr(scn_wr),
        .scan_data(scn_d), .display_on_wr(on_wr), .display_on_data(on_d),
        .line_data(line_d), .display_clock_pin_in(ck_w),
        .display_clock_pin_out(ck_o), .display_clock_pin_oe(ck_oe),
        .frame_polarity_in(fr_w), .frame_polarity_out(fr_o),
        .frame_polarity_oe(fr_oe), .display_off_sync_n_in(off_w),
        .display_off_sync_n_out(off_o), .display_off_sync_n_oe(off_oe),
        .seg_out(seg), .com_active(com), .com_enable(com_en),
        .drive_polarity(drv_pol), .line_fetch(fetch), .osc_running(osc),
        .boost_en(bst), .regulator_en(rg), .follower_en(fl),
        .volume_level(vol_lv));
    ltpc_far_side far (.clk(clk), .run(run), .pol(pol), .on(on),
        .ck_o(ck_o), .ck_oe(ck_oe), .fr_o(fr_o), .fr_oe(fr_oe),
        .off_o(off_o), .off_oe(off_oe), .ck_w(ck_w), .fr_w(fr_w),
        .off_w(off_w));
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    function automatic logic [131:0] obs(int id);
        case (id)
            0: obs = {129'h0, bst, rg, fl};
            1: obs = {126'h0, vol_lv};
            2: obs = {129'h0, ck_oe, fr_oe, off_oe};
            3: obs = {131'h0, osc};
            4: obs = {131'h0, com_en};
            5: obs = seg;
            6: obs = {131'h0, drv_pol};
            7: obs = {126'h0, com};
            8: obs = {131'h0, off_o};
            default: obs = 132'(gap);
        endcase
    endfunction
    task automatic check(string n, logic [131:0] s, logic [131:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic expect_v(int id, logic [131:0] e);
        id_q.push_back(id);
        exp_q.push_back(e);
        -> chk_ev;
    endtask
    // watcher drains every note, so two notes in one step are not lost
    initial forever begin
        @(chk_ev);
        while (id_q.size() > 0) begin
            check(nm[id_q[0]], obs(id_q[0]), exp_q.pop_front());
            void'(id_q.pop_front());
        end
    end
    task automatic end_sim;
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // stimulus: strobes go up and down on falling edges
    // ------------------------------------------------------------
    task automatic wr(int k, logic [5:0] d);
        @(negedge clk);
        {pwr_wr, vol_wr, scn_wr, on_wr} = 4'h8 >> k;
        pwr_d = d[2:0];
        vol_d = (k == 1) ? d : vol_d;  // keep last volume for later notes
        scn_d = d[0];
        on_d = d[0];
        @(negedge clk);
        {pwr_wr, vol_wr, scn_wr, on_wr} = 4'h0;
        @(posedge clk) #10;
    endtask
    // poll for the line start pulse, then let the latch load land
    task automatic wait_fetch;
        int n;
        n = 0;
        do begin
            @(posedge clk) #1;
            n++;
        end while (fetch !== 1'b1 && n < 1000);
        repeat (2) @(posedge clk);
        #10;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard: the whole run needs well under 70000 cycles
    initial begin
        cyc = 0;
        while (cyc < 80000) begin
            @(posedge clk);
            cyc++;
        end
        n_fail++;
        end_sim;
    end
    initial begin
        {rst_n, pwr_wr, vol_wr, scn_wr, on_wr, scn_d, on_d} = 7'h00;
        {run, pol, on, pwr_d, vol_d, line_d, gap} = '0;
        {osel, mst, seed, n_fail, check_count} = {2'h3, 32'd59, 64'd0};
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(posedge clk) #10;
        expect_v(1, 31);
        expect_v(0, 0);
        expect_v(4, 0);
        expect_v(5, 0);
        expect_v(2, 7);
        expect_v(3, 1);
        // only the four useful patterns, twice; all-off comes last so the
        // oscillator may be stopped later with the booster already off
        for (i = 0; i < 8; i++) begin
            wr(0, 6'h07 >> (i % 4));
            expect_v(0, 6'h07 >> (i % 4));
        end
        for (i = 0; i < 6; i++) begin
            v = (i < 2) ? {6{i[0]}} : 6'($random(seed));
            wr(1, v);
            expect_v(1, 6'h3f - v);
        end
        wr(3, 6'h01);
        @(negedge clk);
        line_d = 132'({$random(seed), $random(seed), $random(seed),
                       $random(seed), $random(seed)});
        wait_fetch;
        old = line_d;
        // host traffic and new memory data mid-line leave the latch alone
        @(negedge clk) line_d = ~line_d;
        wr(1, v);
        expect_v(5, old);
        expect_v(4, 1);
        expect_v(8, 1);
        for (i = 0; i < 2; i++) begin
            wr(2, 6'(i));
            wait_fetch;
            v = com;
            wait_fetch;
            expect_v(7, i ? 6'(v - 6'h01) : 6'(v + 6'h01));
        end
        expect_v(1, 6'h3f - vol_d);
        fo = fr_o;
        // sample just after each edge, once the polarity flop has settled
        for (i = 0; i < 30000 && fr_o === fo; i++) begin
            @(posedge clk) #1;
        end
        fo = fr_o;
        while (fr_o === fo && gap < 30000) begin
            @(posedge clk) #1;
            gap++;
        end
        expect_v(9, 25600);
        wr(3, 6'h00);
        expect_v(8, 0);
        expect_v(5, 0);
        expect_v(4, 0);
        @(negedge clk) osel = 1'b0;
        @(posedge clk) #10;
        expect_v(2, 3);
        expect_v(3, 0);
        @(negedge clk) {mst, osel, run, pol, on} = 5'h0f;
        line_d = ~line_d;  // new data, so only a slave fetch can show it
        @(posedge clk) #10;
        expect_v(2, 0);
        expect_v(3, 0);
        wait_fetch;
        expect_v(6, 1);
        expect_v(4, 1);
        expect_v(5, line_d);
        @(negedge clk) pol = 1'b0;
        repeat (3) @(posedge clk);
        #10;
        expect_v(6, 0);
        // a second reset mid-run must restore volume and normal scan
        @(negedge clk) rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(posedge clk) #10;
        expect_v(1, 31);
        expect_v(7, 0);
        @(posedge clk) #10;
        end_sim;
    end
endmodule
